//--- rtl/jaes_defs.svh
// Constants of the jitter-attenuating elastic store.
// Assumes a single 40 MHz system clock; included by its bare name.
`ifndef JAES_DEFS_SVH
`define JAES_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define JAES_CLK_HZ        40000000
`define JAES_INIT_MS       3
`define JAES_INIT_CYCLES   (`JAES_INIT_MS * (`JAES_CLK_HZ / 1000))
`define JAES_EVAL_US       200
`define JAES_EVAL_CYCLES   (`JAES_EVAL_US * (`JAES_CLK_HZ / 1000000))

// ----------------------------------------------------------------------
// FIFO geometry
// ----------------------------------------------------------------------
`define JAES_DEPTH         16
`define JAES_WR_RST        4'h0
`define JAES_RD_RST        4'h7
`define JAES_OCC_RST       5'h09
`define JAES_OCC_HALF      5'h08
`define JAES_OCC_FULL      5'h10
`define JAES_INVALID_BITS  5'h10

// ----------------------------------------------------------------------
// Oscillator: phase steps per 40 MHz cycle, 32-bit accumulator
// ----------------------------------------------------------------------
`define JAES_NCO_T1        32'h2786c226
`define JAES_STEP_T1       32'h0000a860
`define JAES_NCO_CEPT      32'h346dc5d6
`define JAES_STEP_CEPT     32'h000055e6
`define JAES_STEP_MIN      3'h0
`define JAES_STEP_MID      3'h2
`define JAES_STEP_MAX      3'h4

`endif

//--- rtl/jaes_pkg.sv
// Types shared by the elastic store modules.
// Assumes nothing beyond a SystemVerilog compiler.
package jaes_pkg;
    // Tracking phase, Gray coded
    typedef enum logic [1:0] {
        JAES_PH_INIT = 2'h0,
        JAES_PH_RUN  = 2'h1
    } jaes_phase_t;
endpackage : jaes_pkg

//--- rtl/jaes_sync.sv
// Pin input synchroniser with agreement filter.
// Assumes asynchronous pins and one system clock.
`timescale 1ns/1ps
module jaes_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    // Pins and filtered levels
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] level_ff;

    // ------------------------------------------------------------------
    // Three stages, change taken once stages two and three agree
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_ff  <= '0;
            s2_ff    <= '0;
            s3_ff    <= '0;
            level_ff <= '0;
        end else begin
            meta_ff  <= i_pin;
            s2_ff    <= meta_ff;
            s3_ff    <= s2_ff;
            level_ff <= (s2_ff & ~(s2_ff ^ s3_ff))
                      | (level_ff & (s2_ff ^ s3_ff));
        end
    end

    assign o_level = level_ff;
endmodule : jaes_sync

//--- rtl/jaes_osc.sv
// Stepped numerically controlled oscillator, divided by four.
// Assumes the 40 MHz system clock; runs through pointer reset.
`include "jaes_defs.svh"
`timescale 1ns/1ps
module jaes_osc (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // Control
    input  wire logic       i_rate_cept,
    input  wire logic [2:0] i_step,
    // Divided output
    output logic            o_div4
);
    logic [31:0] acc_ff;
    logic [32:0] nxt_acc;
    logic [1:0]  div_ff;

    function automatic logic [31:0] step_inc(input logic cept,
                                             input logic [2:0] idx);
        logic [31:0] base;
        logic [31:0] unit;
        base = cept ? `JAES_NCO_CEPT : `JAES_NCO_T1;
        unit = cept ? `JAES_STEP_CEPT : `JAES_STEP_T1;
        step_inc = base - (unit * 32'(`JAES_STEP_MID))
                 + (unit * 32'(idx));
    endfunction : step_inc

    // ------------------------------------------------------------------
    // Oscillator period per accumulator wrap, five settings
    // ------------------------------------------------------------------
    assign nxt_acc = {1'b0, acc_ff} + {1'b0, step_inc(i_rate_cept, i_step)};

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            acc_ff <= '0;
        end else begin
            acc_ff <= nxt_acc[31:0];
        end
    end

    // Divide by four
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            div_ff <= 2'h0;
        end else if (nxt_acc[32]) begin
            div_ff <= div_ff + 2'h1;
        end
    end

    assign o_div4 = div_ff[1];
endmodule : jaes_osc

//--- rtl/jaes_top.sv
// Jitter-attenuating elastic store, device side.
// Assumes 40 MHz i_clk; the six synchronised pins are asynchronous to it, i_rate_cept and i_sys_rst are used unsynchronised.
`include "jaes_defs.svh"
`timescale 1ns/1ps
module jaes_top
    import jaes_pkg::*;
#(
    parameter int INIT_CYCLES = `JAES_INIT_CYCLES,
    parameter int EVAL_CYCLES = `JAES_EVAL_CYCLES
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // Line side
    input  wire logic       i_jittered_clock_in,
    input  wire logic       i_serial_data_in,
    // Slave read clock
    input  wire logic       i_external_read_clock,
    input  wire logic       i_external_read_select,
    // Control pins
    input  wire logic       i_slip_reset_n,
    input  wire logic       i_buffer_pointer_reset_n,
    input  wire logic       i_rate_cept,
    // Outputs
    output logic            o_smoothed_clock_out,
    output logic            o_serial_data_out,
    output logic            o_data_valid,
    output logic            o_slip_flag,
    output logic            o_osc_div4,
    output logic [2:0]      o_osc_step
);
    logic [5:0]              pin_level;
    logic                    jclk_lv;
    logic                    din_lv;
    logic                    xclk_lv;
    logic                    xsel_lv;
    logic                    slip_rst_n_lv;
    logic                    ptr_rst_n_lv;
    logic                    osc_div4;
    logic                    jclk_prev_ff;
    logic                    rclk_prev_ff;
    logic                    rclk_src;
    logic                    wr_evt;
    logic                    rd_evt;
    logic                    ovf_evt;
    logic                    unf_evt;
    logic                    slip_evt;
    logic                    eval_evt;
    logic                    init_end;
    logic [`JAES_DEPTH-1:0]  fifo_ff;
    logic [3:0]              wr_ptr_ff;
    logic [3:0]              rd_ptr_ff;
    logic [4:0]              occ_ff;
    logic [4:0]              nxt_occ;
    logic [4:0]              invalid_ff;
    logic [2:0]              step_ff;
    logic [31:0]             eval_cnt_ff;
    logic [31:0]             init_cnt_ff;
    jaes_phase_t             phase_ff;
    logic                    slip_ff;
    logic                    sclk_ff;
    logic                    dout_ff;
    logic                    valid_ff;

    // ------------------------------------------------------------------
    // Pin synchronisers and oscillator
    // ------------------------------------------------------------------
    jaes_sync #(
        .WIDTH (6)
    ) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     ({i_jittered_clock_in, i_serial_data_in,
                     i_external_read_clock, i_external_read_select,
                     i_slip_reset_n, i_buffer_pointer_reset_n}),
        .o_level   (pin_level)
    );

    assign jclk_lv       = pin_level[5];
    assign din_lv        = pin_level[4];
    assign xclk_lv       = pin_level[3];
    assign xsel_lv       = pin_level[2];
    assign slip_rst_n_lv = pin_level[1];
    assign ptr_rst_n_lv  = pin_level[0];

    jaes_osc u_osc (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_rate_cept (i_rate_cept),
        .i_step      (step_ff),
        .o_div4      (osc_div4)
    );

    // ------------------------------------------------------------------
    // Clock edge events
    // ------------------------------------------------------------------
    assign rclk_src = xsel_lv ? xclk_lv : osc_div4;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            jclk_prev_ff <= 1'b0;
            rclk_prev_ff <= 1'b0;
        end else begin
            jclk_prev_ff <= jclk_lv;
            rclk_prev_ff <= rclk_src;
        end
    end

    // Write on input clock fall
    assign wr_evt  = ptr_rst_n_lv & jclk_prev_ff & ~jclk_lv;
    // Read on output clock fall so data is settled at its rise
    assign rd_evt  = ptr_rst_n_lv & rclk_prev_ff & ~rclk_src;
    // Write into unread location, read of unwritten location
    assign ovf_evt = wr_evt & ~rd_evt & (occ_ff == `JAES_OCC_FULL);
    assign unf_evt = rd_evt & ~wr_evt & (occ_ff == 5'h00);
    assign slip_evt = ovf_evt | unf_evt;

    // ------------------------------------------------------------------
    // FIFO storage and pointers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fifo_ff <= '0;
        end else if (wr_evt) begin
            fifo_ff[wr_ptr_ff] <= din_lv;
        end
    end

    always_comb begin
        nxt_occ = occ_ff;
        if (wr_evt && !rd_evt) begin
            nxt_occ = occ_ff + 5'h01;
        end else if (rd_evt && !wr_evt) begin
            nxt_occ = occ_ff - 5'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !ptr_rst_n_lv || slip_evt) begin
            // Rebase reloads both pointers and the occupancy; fifo_ff keeps its stored bits
            wr_ptr_ff <= `JAES_WR_RST;
            rd_ptr_ff <= `JAES_RD_RST;
            occ_ff    <= `JAES_OCC_RST;
        end else begin
            if (wr_evt) begin
                wr_ptr_ff <= wr_ptr_ff + 4'h1;
            end
            if (rd_evt) begin
                rd_ptr_ff <= rd_ptr_ff + 4'h1;
            end
            occ_ff <= nxt_occ;
        end
    end

    // ------------------------------------------------------------------
    // Output data and validity
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            dout_ff <= 1'b0;
        end else if (rd_evt) begin
            dout_ff <= fifo_ff[rd_ptr_ff];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !ptr_rst_n_lv) begin
            invalid_ff <= 5'h00;
        end else if (unf_evt) begin
            invalid_ff <= `JAES_INVALID_BITS;
        end else if (rd_evt && invalid_ff != 5'h00) begin
            invalid_ff <= invalid_ff - 5'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            valid_ff <= 1'b0;
        end else if (unf_evt) begin
            valid_ff <= 1'b0;
        end else if (rd_evt) begin
            valid_ff <= (invalid_ff == 5'h00);
        end
    end

    // ------------------------------------------------------------------
    // Output clock
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !ptr_rst_n_lv) begin
            sclk_ff <= 1'b0;
        end else begin
            sclk_ff <= rclk_src;
        end
    end

    // ------------------------------------------------------------------
    // Init phase and frequency tracking
    // ------------------------------------------------------------------
    assign init_end = (init_cnt_ff >= 32'(INIT_CYCLES - 1));

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            phase_ff    <= JAES_PH_INIT;
            init_cnt_ff <= '0;
        end else if (phase_ff == JAES_PH_INIT) begin
            if (init_end) begin
                phase_ff <= JAES_PH_RUN;
            end else begin
                init_cnt_ff <= init_cnt_ff + 32'h1;
            end
        end
    end

    assign eval_evt = (eval_cnt_ff >= 32'(EVAL_CYCLES - 1));

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !ptr_rst_n_lv || slip_evt || eval_evt) begin
            eval_cnt_ff <= '0;
        end else begin
            eval_cnt_ff <= eval_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !ptr_rst_n_lv || slip_evt) begin
            step_ff <= `JAES_STEP_MID;
        end else if (eval_evt && !xsel_lv) begin
            if (occ_ff > `JAES_OCC_HALF && step_ff != `JAES_STEP_MAX) begin
                step_ff <= step_ff + 3'h1;
            end else if (occ_ff < `JAES_OCC_HALF
                         && step_ff != `JAES_STEP_MIN) begin
                step_ff <= step_ff - 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Slip flag
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            slip_ff <= 1'b1;
        end else if (phase_ff == JAES_PH_INIT) begin
            slip_ff <= !init_end;
        end else if (!slip_rst_n_lv) begin
            slip_ff <= 1'b0;
        end else if (slip_evt) begin
            slip_ff <= 1'b1;
        end
    end

    assign o_smoothed_clock_out = sclk_ff;
    assign o_serial_data_out    = dout_ff;
    assign o_data_valid         = valid_ff;
    assign o_slip_flag          = slip_ff;
    assign o_osc_div4           = osc_div4;
    assign o_osc_step           = step_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_underflow;
        unf_evt && ptr_rst_n_lv;
    endsequence

    sequence s_invalid_start;
        !valid_ff && invalid_ff == `JAES_INVALID_BITS;
    endsequence

    a_init_flag_high: assert property (
        phase_ff == JAES_PH_INIT |-> slip_ff)
        else $error("slip flag low during init");

    a_init_release: assert property (
        phase_ff == JAES_PH_INIT && init_end |=> !slip_ff)
        else $error("slip flag not released after init");

    a_slip_sets: assert property (
        phase_ff == JAES_PH_RUN
        && slip_evt && slip_rst_n_lv |=> slip_ff)
        else $error("slip event did not set flag");

    a_slip_sticky: assert property (
        phase_ff == JAES_PH_RUN
        && slip_ff && slip_rst_n_lv |=> slip_ff)
        else $error("slip flag dropped without clear");

    a_flag_disabled: assert property (
        phase_ff == JAES_PH_RUN
        && !slip_rst_n_lv && slip_evt |=> !slip_ff)
        else $error("slip flag set while disabled");

    a_slip_clear: assert property (
        phase_ff == JAES_PH_RUN && !slip_rst_n_lv |=> !slip_ff)
        else $error("slip reset did not clear flag");

    a_ovf_rebase: assert property (
        ovf_evt |=> wr_ptr_ff == `JAES_WR_RST
                    && rd_ptr_ff == `JAES_RD_RST
                    && occ_ff == `JAES_OCC_RST)
        else $error("overflow did not discard contents");

    a_unf_invalid: assert property (
        s_underflow |=> s_invalid_start)
        else $error("underflow did not mark invalid bits");

    a_relock_step: assert property (
        slip_evt |=> step_ff == `JAES_STEP_MID && eval_cnt_ff == 32'h0)
        else $error("tracking not restarted after slip");

    a_ptr_reset_hold: assert property (
        !ptr_rst_n_lv |=> wr_ptr_ff == `JAES_WR_RST
                          && rd_ptr_ff == `JAES_RD_RST && !sclk_ff)
        else $error("pointer reset state wrong");

    a_wr_advance: assert property (
        wr_evt && !slip_evt |=> wr_ptr_ff == $past(wr_ptr_ff) + 4'h1)
        else $error("write pointer did not advance");

    a_step_up: assert property (
        eval_evt && ptr_rst_n_lv && !slip_evt && !xsel_lv
        && occ_ff > `JAES_OCC_HALF && step_ff != `JAES_STEP_MAX
        |=> step_ff == $past(step_ff) + 3'h1)
        else $error("oscillator not stepped up");

    a_step_down: assert property (
        eval_evt && ptr_rst_n_lv && !slip_evt && !xsel_lv
        && occ_ff < `JAES_OCC_HALF && step_ff != `JAES_STEP_MIN
        |=> step_ff == $past(step_ff) - 3'h1)
        else $error("oscillator not stepped down");

    a_slave_clock: assert property (
        xsel_lv && ptr_rst_n_lv |=> sclk_ff == $past(xclk_lv))
        else $error("output clock not following external clock");

    a_rd_advance: assert property (
        rd_evt && !slip_evt |=> rd_ptr_ff == $past(rd_ptr_ff) + 4'h1)
        else $error("read pointer did not advance");

    a_fifo_store: assert property (
        wr_evt |=> fifo_ff[$past(wr_ptr_ff)] == $past(din_lv))
        else $error("input bit not stored at write pointer");

    a_valid_recover: assert property (
        rd_evt && !unf_evt && invalid_ff == 5'h00
        |=> valid_ff)
        else $error("valid not restored after invalid bits");
endmodule : jaes_top

//--- test/jaes_line_model.sv
// Line-side partner: jittered clock, serial data, slave read clock.
// Assumes the bench sets run and the half period in ns.
`timescale 1ns/1ps
module jaes_line_model (
    // Control
    input  wire logic i_run,
    input  real       i_half_ns,
    // Line pins
    output logic      o_line_clk,
    output logic      o_line_data,
    output logic      o_ext_clk = 1'b0
);
    // ------------------------------------------------------------
    // Clock with jitter and a repeating data pattern
    // ------------------------------------------------------------
    localparam logic [6:0] PAT = 7'h74;
    int idx = 0;
    bit jit = 1'b0;

    initial begin
        o_line_clk = 1'b0;
        o_line_data = 1'b0;
        forever begin
            if (i_run) begin
                #(i_half_ns + (jit ? 40.0 : -40.0));
                o_line_clk = ~o_line_clk;
                if (o_line_clk) begin
                    // Data moves on rise, far from the sampling fall
                    o_line_data = PAT[idx];
                    idx = (idx + 1) % 7;
                    jit = ~jit;
                end
            end else begin
                o_line_clk = 1'b0;
                #100 o_line_data = ~o_line_data;
            end
        end
    end

    // Slave read clock, same average rate as the line clock
    always @(o_line_clk) o_ext_clk <= #(i_half_ns / 2.0) o_line_clk;
endmodule : jaes_line_model

//--- test/jitter_attenuator_elastic_store_test.sv
// Bench for the elastic store: rate rows, then slip and slave cases.
// Assumes jaes_top, the line model and a 40 MHz clock.
`timescale 1ns/1ps
module jitter_attenuator_elastic_store_test;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int         INIT = 50;
    localparam logic [6:0] PAT  = 7'h74;
    typedef struct { logic c; real h; int d; } jaes_row_t;
    logic       i_clk      = 1'b0;
    logic       i_sys_rst  = 1'b1;
    logic       sel        = 1'b0;
    logic       slip_rst_n = 1'b1;
    logic       ptr_rst_n  = 1'b0;
    logic       cept       = 1'b0;
    logic       run        = 1'b0;
    real        half_ns    = 323.8;
    logic       lclk, ldata, eclk, sclk, dout, valid, flag, div4;
    logic [2:0] step;
    int         num_errors = 0;
    int         n_checks   = 0;
    int         nin = 0, nout = 0, ndiv = 0;
    logic [1:0] q[$];
    jaes_row_t  rows[2] = '{'{1'b0, 323.8, 154}, '{1'b1, 244.1, 205}};

    always #12.5 i_clk = ~i_clk;
    always @(negedge lclk) nin++;
    always @(posedge div4) ndiv++;
    always @(posedge sclk) begin
        nout++;
        q.push_back({dout, valid});
    end

    jaes_line_model jaes_line_model_i (
        .i_run(run), .i_half_ns(half_ns),
        .o_line_clk(lclk), .o_line_data(ldata), .o_ext_clk(eclk)
    );
    jaes_top #(.INIT_CYCLES(INIT), .EVAL_CYCLES(64)) jaes_top_i (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_jittered_clock_in(lclk), .i_serial_data_in(ldata),
        .i_external_read_clock(eclk), .i_external_read_select(sel),
        .i_slip_reset_n(slip_rst_n), .i_buffer_pointer_reset_n(ptr_rst_n),
        .i_rate_cept(cept), .o_smoothed_clock_out(sclk),
        .o_serial_data_out(dout), .o_data_valid(valid),
        .o_slip_flag(flag), .o_osc_div4(div4), .o_osc_step(step)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk

    task automatic cyc(int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc

    task automatic restart(logic c, real h);
        run <= 1'b0;
        ptr_rst_n <= 1'b0;
        cept <= c;
        half_ns <= h;
        cyc(200);
        ptr_rst_n <= 1'b1;
        run <= 1'b1;
        q.delete();
    endtask : restart

    // Fewest mismatches of the read stream over all pattern phases
    function automatic int stream_bad();
        int bad;
        bad = 99;
        if (q.size() < 60) return bad;
        for (int s = 0; s < 7; s++) begin
            int e;
            e = 0;
            for (int j = 24; j < q.size(); j++)
                if (q[j] !== {PAT[(s + j) % 7], 1'b1}) e++;
            if (e < bad) bad = e;
        end
        return bad;
    endfunction : stream_bad

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    initial begin
        #1500000;
        num_errors++;
        summarize();
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        logic hi;
        int   base;
        int   zeros;
        cyc(3);
        i_sys_rst <= 1'b0;
        cyc(2);
        chk("init_flag", flag, 1);
        cyc(INIT - 4);
        chk("init_hold", flag, 1);
        cyc(12);
        chk("init_done", flag, 0);
        chk("ptr_step", step, 3'h2);
        hi = 1'b0;
        ndiv = 0;
        repeat (400) begin
            cyc(1);
            hi = hi | sclk;
        end
        chk("ptr_clk_low", hi, 0);
        chk("osc_runs", ndiv > 10, 1);
        foreach (rows[r]) begin
            restart(rows[r].c, rows[r].h);
            cyc(400);
            nin = 0;
            nout = 0;
            ndiv = 0;
            cyc(4000);
            chk("div4_rate", (ndiv - rows[r].d) inside {[-2:2]}, 1);
            chk("rate_match", (nin - nout) inside {[-6:6]}, 1);
            chk("stream", stream_bad(), 0);
            chk("no_slip", flag, 0);
        end
        restart(1'b0, 290.0);
        for (int k = 0; k < 1500 && step !== 3'h4; k++) cyc(1);
        chk("step_up", step, 3'h4);
        for (int k = 0; k < 6000 && flag !== 1'b1; k++) cyc(1);
        chk("ovf_flag", flag, 1);
        cyc(1);
        chk("relock_step", step, 3'h2);
        slip_rst_n <= 1'b0;
        cyc(3000);
        chk("flag_disabled", flag, 0);
        slip_rst_n <= 1'b1;
        restart(1'b0, 400.0);
        for (int k = 0; k < 1000 && step !== 3'h0; k++) cyc(1);
        chk("step_down", step, 3'h0);
        for (int k = 0; k < 4000 && flag !== 1'b1; k++) cyc(1);
        chk("unf_flag", flag, 1);
        base = q.size();
        for (int k = 0; k < 2000 && q.size() < base + 30; k++) cyc(1);
        zeros = 0;
        foreach (q[j])
            if (q[j][0] === 1'b0) zeros++;
        chk("invalid_bits", zeros, 16 + 1);
        slip_rst_n <= 1'b0;
        cyc(8);
        slip_rst_n <= 1'b1;
        sel <= 1'b1;
        restart(1'b0, 323.8);
        cyc(600);
        hi = 1'b1;
        repeat (20) begin
            @(posedge eclk);
            cyc(8);
            hi = hi & sclk;
        end
        chk("follow", hi, 1);
        cyc(3000);
        chk("slave_slip", flag, 0);
        chk("slave_stream", stream_bad(), 0);
        summarize();
    end
endmodule : jitter_attenuator_elastic_store_test
